// [hdl/ext_signal_capture.sv]
// What this block does
// - use request lines two to seven only
// - take interruption at boundary when mask set
// - save old word, load new word
// - pending requests go into code field
// - lines two..seven map onto bits 26..31
// - requests sampled on REF_CLK through a two-stage synchroniser at any time
// - requests stay pending until honoured
// - present all pending together, then clear
// - repeated pulses merge into one request
// - stuck-high line cannot cause endless interruptions
// - outgoing timing pulses keep width and gap limits
// external request capture and interruption swap for the processor
// assumes the core reports instruction boundaries and accepts the swap in one cycle
`include "sig_capture_defines.svh"
`default_nettype none
module ext_signal_capture #(
   parameter int LINES = 8
) (
   input wire logic REF_CLK,
   input wire logic RST_N,
   input wire logic [LINES-1:0] SIG_IN,
   input wire logic INSN_DONE,
   input wire logic [31:0] PROGRAM_STATUS_WORD,
   input wire logic [LINES-1:0] TIMING_FIRE,
   output logic TAKE_INT,
   output sig_capture_pkg::swap_type SWAP,
   output logic [5:0] PENDING,
   output logic [LINES-1:0] SIG_OUT,
   output logic [LINES-1:0] SIG_OUT_BUSY
);
   logic rst_meta_r;
   logic rst_r;
   logic [5:0] meta_r;
   logic [5:0] sync_r;
   logic [5:0] prev_r;
   logic [5:0] pend_r;
   logic [5:0] pend_nxt;
   logic take_r;
   logic fresh_r;
   sig_capture_pkg::swap_type swap_r;
   logic [LINES-1:0] tp_pulse;
   logic [LINES-1:0] tp_busy;
   logic [LINES-1:0] out_r;
   logic [LINES-1:0] busy_r;

   function automatic logic [31:0] fold_code(input logic [31:0] word,
         input sig_capture_pkg::code_type code);
      logic [31:0] merged;
      merged = word;
      merged[`CODE_MSB:`CODE_LSB] = code;
      return merged;
   endfunction

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         rst_meta_r <= 1'b0;
         rst_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_r <= rst_meta_r;
      end
   end

   // lines 0 and 1 are terminated only
   wire [5:0] req_raw = SIG_IN[`REQ_LAST:`REQ_FIRST];
   always_ff @(posedge REF_CLK or negedge rst_r) begin
      if (!rst_r) begin
         meta_r <= '0;
         sync_r <= '0;
         prev_r <= '0;
      end else begin
         meta_r <= req_raw;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end
   wire [5:0] rise = sync_r & ~prev_r;
   // interruption take and status swap
   wire mask_on = PROGRAM_STATUS_WORD[`SYS_MASK_BIT];
   wire at_boundary = INSN_DONE && mask_on;
   wire take = at_boundary && (pend_r != '0) && !take_r;
   // new edge in the taking cycle survives the clear
   assign pend_nxt = (take ? 6'h00 : pend_r) | rise;

   always_ff @(posedge REF_CLK or negedge rst_r) begin
      if (!rst_r) begin
         pend_r <= '0;
         take_r <= 1'b0;
         swap_r <= '0;
      end else begin
         pend_r <= pend_nxt;
         take_r <= take;
         if (take) begin
            swap_r.old_addr <= `EXT_OLD_ADDR;
            swap_r.new_addr <= `EXT_NEW_ADDR;
            swap_r.old_word <= fold_code(PROGRAM_STATUS_WORD, pend_r);
         end
      end
   end

   // a take needs a fresh edge since the one before
   always_ff @(posedge REF_CLK or negedge rst_r) begin
      if (!rst_r) begin
         fresh_r <= 1'b0;
      end else begin
         fresh_r <= (rise != '0) || (fresh_r && !take);
      end
   end

   // outgoing timing pulse lines
   genvar g;
   generate
      for (g = 0; g < LINES; g++) begin : tp
         timing_pulse_gen u_gen (
            .clk(REF_CLK),
            .rst_n(rst_r),
            .fire(TIMING_FIRE[g]),
            .pulse(tp_pulse[g]),
            .busy(tp_busy[g])
         );
         busy_start_a: assert property (@(posedge REF_CLK) disable iff (!rst_r)
            $rose(SIG_OUT_BUSY[g]) |-> SIG_OUT[g])
            else $error("timing line busy without pulse");
         gap_busy_a: assert property (@(posedge REF_CLK) disable iff (!rst_r)
            $fell(SIG_OUT[g]) |-> SIG_OUT_BUSY[g])
            else $error("timing gap not held busy");
         busy_end_a: assert property (@(posedge REF_CLK) disable iff (!rst_r)
            $fell(SIG_OUT_BUSY[g]) |-> !SIG_OUT[g])
            else $error("timing line released while high");
      end
   endgenerate
   always_ff @(posedge REF_CLK or negedge rst_r) begin
      if (!rst_r) begin
         out_r <= '0;
         busy_r <= '0;
      end else begin
         out_r <= tp_pulse;
         busy_r <= tp_busy;
      end
   end

   assign TAKE_INT = take_r;
   assign SWAP = swap_r;
   assign PENDING = pend_r;
   assign SIG_OUT = out_r;
   assign SIG_OUT_BUSY = busy_r;

   mask_gate_a: assert property (@(posedge REF_CLK) disable iff (!rst_r)
      TAKE_INT |-> $past(mask_on) && $past(INSN_DONE))
      else $error("interruption taken without mask or boundary");
   code_field_a: assert property (@(posedge REF_CLK) disable iff (!rst_r)
      TAKE_INT |-> SWAP.old_word[`CODE_MSB:`CODE_LSB] == $past(pend_r))
      else $error("code field not pending set");
   swap_addr_a: assert property (@(posedge REF_CLK) disable iff (!rst_r)
      TAKE_INT |-> SWAP.old_addr == `EXT_OLD_ADDR && SWAP.new_addr == `EXT_NEW_ADDR)
      else $error("swap addresses wrong");
   hold_pend_a: assert property (@(posedge REF_CLK) disable iff (!rst_r)
      !take |=> (pend_r & $past(pend_r)) == $past(pend_r))
      else $error("pending request lost");
   clear_pend_a: assert property (@(posedge REF_CLK) disable iff (!rst_r)
      take |=> pend_r == $past(rise))
      else $error("pending not cleared on take");
   edge_set_a: assert property (@(posedge REF_CLK) disable iff (!rst_r)
      $rose(req_raw[0]) ##1 1'b1 ##1 !take |=> pend_r[0])
      else $error("rising edge not latched");
   stuck_high_a: assert property (@(posedge REF_CLK) disable iff (!rst_r)
      req_raw[0] [*4] ##1 take |=> !pend_r[0])
      else $error("stuck line repeats request");
   line_unused_a: assert property (@(posedge REF_CLK) disable iff (!rst_r)
      $changed(SIG_IN[1:0]) && $stable(SIG_IN[7:2]) |-> ##3 $stable(pend_r) || $past(take))
      else $error("lines 0 or 1 affect pending");
   take_single_a: assert property (@(posedge REF_CLK) disable iff (!rst_r)
      TAKE_INT |=> !TAKE_INT)
      else $error("interruption pulse longer than one cycle");
   take_space_a: assert property (@(posedge REF_CLK) disable iff (!rst_r)
      TAKE_INT |-> !take)
      else $error("second take right after a take");
   swap_hold_a: assert property (@(posedge REF_CLK) disable iff (!rst_r)
      !TAKE_INT |-> $stable(SWAP))
      else $error("swap record changed without take");
   mask_block_a: assert property (@(posedge REF_CLK) disable iff (!rst_r)
      !at_boundary |=> !TAKE_INT)
      else $error("take outside boundary or with mask off");
   old_word_a: assert property (@(posedge REF_CLK) disable iff (!rst_r)
      TAKE_INT |-> SWAP.old_word[`CODE_LSB-1:0] == $past(PROGRAM_STATUS_WORD[`CODE_LSB-1:0]))
      else $error("status word not saved");
   pend_take_a: assert property (@(posedge REF_CLK) disable iff (!rst_r)
      at_boundary && PENDING != '0 && !TAKE_INT |=> TAKE_INT)
      else $error("pending request not honoured at boundary");
   code_nonzero_a: assert property (@(posedge REF_CLK) disable iff (!rst_r)
      TAKE_INT |-> SWAP.old_word[`CODE_MSB:`CODE_LSB] != '0)
      else $error("interruption with empty code");
   report_clear_a: assert property (@(posedge REF_CLK) disable iff (!rst_r)
      TAKE_INT |-> (PENDING & ~$past(rise)) == '0)
      else $error("reported request still pending");
   fresh_edge_a: assert property (@(posedge REF_CLK) disable iff (!rst_r)
      take |-> fresh_r)
      else $error("take without a new request edge");
   out_busy_a: assert property (@(posedge REF_CLK) disable iff (!rst_r)
      (SIG_OUT & ~SIG_OUT_BUSY) == '0)
      else $error("timing pulse outside busy time");
   new_from_edge_a: assert property (@(posedge REF_CLK) disable iff (!rst_r)
      (PENDING & ~$past(PENDING) & ~$past(rise)) == '0)
      else $error("pending set without an edge");

   // per-line request checks
   generate
      for (g = 0; g < 6; g++) begin : line_chk
         map_bit_a: assert property (@(posedge REF_CLK) disable iff (!rst_r)
            $rose(req_raw[g]) ##1 1'b1 ##1 !take |=> PENDING[g])
            else $error("request line not mapped to its bit");
         stuck_bit_a: assert property (@(posedge REF_CLK) disable iff (!rst_r)
            req_raw[g] [*4] ##1 take |=> !PENDING[g])
            else $error("held line reported again");
         hold_bit_a: assert property (@(posedge REF_CLK) disable iff (!rst_r)
            PENDING[g] && !take |=> PENDING[g])
            else $error("pending bit dropped without take");
      end
   endgenerate
endmodule // ext_signal_capture
`default_nettype wire

// [hdl/sig_capture_defines.svh]
// timing constants and field positions for the external signal capture block
// assumes REF_CLK at 200 MHz
`ifndef SIG_CAPTURE_DEFINES_SVH
`define SIG_CAPTURE_DEFINES_SVH
`define CLK_PERIOD_NS 5
`define PULSE_MIN_NS 500
`define PULSE_MAX_NS 1000
`define GAP_MIN_NS 500
// least widths round up, longest rounds down
`define PULSE_MIN_CYC ((`PULSE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PULSE_MAX_CYC (`PULSE_MAX_NS / `CLK_PERIOD_NS)
`define GAP_MIN_CYC ((`GAP_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define EXT_OLD_ADDR 12'h018
`define EXT_NEW_ADDR 12'h058
`define SYS_MASK_BIT 7
`define CODE_LSB 26
`define CODE_MSB 31
`define REQ_FIRST 2
`define REQ_LAST 7
`define TIMER_W 8
`endif

// [hdl/sig_capture_pkg.sv]
// types for the external signal capture block
// assumes sig_capture_defines.svh sits beside it
`default_nettype none
package sig_capture_pkg;
   typedef logic [5:0] code_type;
   typedef struct packed {
      logic [11:0] addr;
      logic [31:0] data;
   } store_type;
   typedef struct packed {
      logic [11:0] old_addr;
      logic [11:0] new_addr;
      logic [31:0] old_word;
   } swap_type;
   typedef enum logic [1:0] {
      PIDLE = 2'b00,
      PHIGH = 2'b01,
      PLOW = 2'b11
   } pulse_state_type;
endpackage
`default_nettype wire

// [hdl/timing_pulse_gen.sv]
// one outgoing timing pulse line with bounded width and gap
// assumes REF_CLK at 200 MHz and a reset already synchronised
`include "sig_capture_defines.svh"
`default_nettype none
module timing_pulse_gen #(
   parameter int WIDTH_CYC = `PULSE_MIN_CYC + 10,
   parameter int GAP_CYC = `GAP_MIN_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic fire,
   output logic pulse,
   output logic busy
);
   sig_capture_pkg::pulse_state_type state_r, state_nxt;
   logic [`TIMER_W-1:0] cnt_r, cnt_nxt;
   wire last_high = cnt_r == `TIMER_W'(WIDTH_CYC - 1);
   wire last_low = cnt_r == `TIMER_W'(GAP_CYC - 1);
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r + `TIMER_W'(1);
      unique case (state_r)
         sig_capture_pkg::PIDLE: begin
            cnt_nxt = '0;
            if (fire) state_nxt = sig_capture_pkg::PHIGH;
         end
         sig_capture_pkg::PHIGH: begin
            if (last_high) begin
               state_nxt = sig_capture_pkg::PLOW;
               cnt_nxt = '0;
            end
         end
         sig_capture_pkg::PLOW: begin
            if (last_low) state_nxt = sig_capture_pkg::PIDLE;
         end
      endcase
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= sig_capture_pkg::PIDLE;
         cnt_r <= '0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
      end
   end
   assign pulse = state_r == sig_capture_pkg::PHIGH;
   assign busy = state_r != sig_capture_pkg::PIDLE;

   // run lengths of the line as seen outside, for the width and gap checks
   logic [`TIMER_W-1:0] high_len_r;
   logic [`TIMER_W-1:0] low_len_r;
   wire low_full = low_len_r == '1;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         high_len_r <= '0;
         low_len_r <= '1;
      end else begin
         high_len_r <= pulse ? high_len_r + `TIMER_W'(1) : '0;
         low_len_r <= pulse ? '0 : (low_full ? low_len_r : low_len_r + `TIMER_W'(1));
      end
   end

   pulse_width_a: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(pulse) |-> high_len_r >= `PULSE_MIN_CYC && high_len_r <= `PULSE_MAX_CYC)
      else $error("timing pulse width wrong");
   pulse_long_a: assert property (@(posedge clk) disable iff (!rst_n)
      pulse |-> high_len_r < `PULSE_MAX_CYC)
      else $error("timing pulse too long");
   gap_len_a: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(pulse) |-> low_len_r >= `GAP_MIN_CYC)
      else $error("timing gap below minimum");
   pulse_gap_a: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(pulse) |-> !pulse [*8])
      else $error("timing pulse gap too short");
endmodule // timing_pulse_gen
`default_nettype wire

// [verif/ext_requester.sv]
// request source model standing in for the far-side equipment
// assumes the bench spaces pulses by more than pulse plus gap time
`default_nettype none
module ext_requester (
   input wire logic clk,
   input wire logic [7:0] fire,
   input wire logic [7:0] stuck,
   input wire logic [7:0] width,
   output logic [7:0] sig
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] act_r = 8'h00;
   int cnt_r = 0;
   always @(posedge clk) begin
      if (cnt_r > 1) begin
         cnt_r <= cnt_r - 1;
      end else if (fire != 8'h00) begin
         act_r <= fire;
         cnt_r <= 100 + int'(width);
      end else begin
         act_r <= 8'h00;
         cnt_r <= 0;
      end
   end
   assign sig = act_r | stuck;
endmodule // ext_requester
`default_nettype wire

// [verif/testbench.sv]
// self-checking bench for the external request capture block
// assumes the design package and the request source model are compiled first
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic REF_CLK, RST_N, INSN_DONE, TAKE_INT;
   logic [7:0] SIG_IN, TIMING_FIRE, SIG_OUT, SIG_OUT_BUSY, req, stuck, wid;
   logic [31:0] PROGRAM_STATUS_WORD;
   logic [5:0] PENDING;
   sig_capture_pkg::swap_type SWAP;
   sig_capture_pkg::code_type exp_q[$];
   sig_capture_pkg::code_type e;
   int error_cnt = 0, total_checks = 0, seed = 85281, n, w, g;
   ext_signal_capture DUT (.REF_CLK(REF_CLK), .RST_N(RST_N), .SIG_IN(SIG_IN),
      .INSN_DONE(INSN_DONE), .PROGRAM_STATUS_WORD(PROGRAM_STATUS_WORD),
      .TIMING_FIRE(TIMING_FIRE), .TAKE_INT(TAKE_INT), .SWAP(SWAP), .PENDING(PENDING),
      .SIG_OUT(SIG_OUT), .SIG_OUT_BUSY(SIG_OUT_BUSY));
   ext_requester src (.clk(REF_CLK), .fire(req), .stuck(stuck), .width(wid), .sig(SIG_IN));
   task chk(input logic ok, input string msg);
      total_checks++;
      if (ok !== 1'b1) begin
         error_cnt++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask
   task final_report;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task pulse(input logic [7:0] m);
      @(negedge REF_CLK);
      req = m;
      wid = 8'($unsigned($random(seed)) % 101);
      @(negedge REF_CLK);
      req = 8'h00;
      repeat (320) @(negedge REF_CLK);
   endtask
   task take(input sig_capture_pkg::code_type c);
      exp_q.push_back(c);
      @(negedge REF_CLK);
      INSN_DONE = 1'b1;
      PROGRAM_STATUS_WORD = $random(seed) | 32'h80;
      repeat (8) @(negedge REF_CLK);
      chk(exp_q.size() == 0 && PENDING === 6'h00, "take missing or pending kept");
      INSN_DONE = 1'b0;
   endtask
   always @(posedge REF_CLK) begin
      #1;
      if (TAKE_INT === 1'b1) begin
         chk(exp_q.size() > 0, "take with nothing expected");
         if (exp_q.size() > 0) begin
            e = exp_q.pop_front();
            chk(SWAP.old_word[31:26] === e, "code field");
            chk(SWAP.old_word[25:0] === PROGRAM_STATUS_WORD[25:0], "old word");
            chk(SWAP.old_addr === 12'h018 && SWAP.new_addr === 12'h058, "addresses");
         end
      end
   end
   initial begin
      REF_CLK = 1'b0;
      forever #2.5 REF_CLK = ~REF_CLK;
   end
   initial begin
      #100000;
      error_cnt++;
      final_report();
   end
   initial begin
      RST_N = 1'b0;
      INSN_DONE = 1'b0;
      PROGRAM_STATUS_WORD = 32'h0;
      TIMING_FIRE = 8'h00;
      req = 8'h00;
      stuck = 8'h00;
      wid = 8'h00;
      repeat (6) @(negedge REF_CLK);
      RST_N = 1'b1;
      repeat (4) @(negedge REF_CLK);
      for (int i = 0; i < 8; i++) begin
         @(negedge REF_CLK);
         INSN_DONE = 1'b1;
         PROGRAM_STATUS_WORD = $random(seed) & ~32'h80;
         pulse(8'(1 << i));
         chk(PENDING === 6'((1 << i) >> 2), "line map");
         if (i >= 2) take(6'(1 << (i - 2)));
      end
      pulse(8'h04);
      pulse(8'h04);
      pulse(8'h80);
      chk(PENDING === 6'h21, "merged pending");
      take(6'h21);
      stuck = 8'h04;
      repeat (10) @(negedge REF_CLK);
      take(6'h01);
      @(negedge REF_CLK);
      INSN_DONE = 1'b1;
      repeat (300) @(negedge REF_CLK);
      chk(PENDING === 6'h00, "stuck line");
      INSN_DONE = 1'b0;
      stuck = 8'h00;
      n = $unsigned($random(seed)) % 8;
      TIMING_FIRE = 8'(1 << n);
      @(negedge REF_CLK);
      TIMING_FIRE = 8'h00;
      w = 0;
      g = 0;
      repeat (1) @(negedge REF_CLK);
      while (SIG_OUT[n] === 1'b1 && w < 300) begin
         w++;
         @(negedge REF_CLK);
      end
      while (SIG_OUT_BUSY[n] === 1'b1 && g < 300) begin
         g++;
         @(negedge REF_CLK);
      end
      chk(w >= 100 && w <= 200, "timing width");
      chk(g >= 100 && g < 300, "timing gap");
      final_report();
   end
endmodule // testbench
`default_nettype wire
